/* logic/scf_pkg.sv */
/*
  Package for the system configuration frame block: frame layout, field
  positions, reset values and state encodings.
  Assumes nothing of its surroundings; every user writes scf_pkg::name.
*/
`default_nettype none
package scf_pkg;

  // frame length and counter sizing
  localparam int unsigned FRAME_BITS = 16;
  localparam int unsigned CNT_W      = 6;
  localparam logic [5:0]  CNT_MAX    = 6'h3F;

  // address field, top two bits of the frame
  localparam int unsigned ADDR_HI    = 15;
  localparam int unsigned ADDR_LO    = 14;
  localparam logic [1:0]  ADDR_SYSCFG = 2'h2;

  // control bits of the frame
  localparam int unsigned RRS_POS    = 13;
  localparam int unsigned NOWR_POS   = 12;

  // reserved bits that the host keeps at zero
  localparam int unsigned RSV_HI     = 11;
  localparam int unsigned RSV_LO     = 9;

  // stored configuration fields
  localparam int unsigned CFG_W      = 9;
  localparam int unsigned RLC_POS    = 8;
  localparam int unsigned AUX_HI     = 7;
  localparam int unsigned AUX_LO     = 6;
  localparam logic [8:0]  CFG_RESET  = 9'h000;

  // auxiliary supply codes
  localparam logic [1:0]  AUX_OFF    = 2'h0;
  localparam logic [1:0]  AUX_ON     = 2'h1;

  // rising-edge counts at which header bits have been sampled
  localparam logic [5:0]  CNT_ADDR_DONE = 6'h02;
  localparam logic [5:0]  CNT_RRS_DONE  = 6'h03;
  localparam logic [5:0]  CNT_FRAME     = 6'h10;

  // frame states, gray along idle -> active -> close
  typedef enum logic [1:0] {
    SCF_IDLE   = 2'h0,
    SCF_ACTIVE = 2'h1,
    SCF_CLOSE  = 2'h3
  } scf_state_t;

endpackage
`default_nettype wire

/* logic/scf_frame_rx.sv */
/*
  Serial frame receiver: edge detection on the serial clock, rising-edge
  counter and MSB-first shift register for one chip-select frame.
  Assumes serial pins already synchronous to clk_in and slower than clk_in/2.
*/
`timescale 1ns/1ps
`default_nettype none
module scf_frame_rx #(
  parameter int unsigned FRAME_BITS = scf_pkg::FRAME_BITS
) (
  input  wire logic                  clk_in,       // system clock
  input  wire logic                  nrst_in,      // async reset, low
  input  wire logic                  sck_in,       // serial clock
  input  wire logic                  mosi_in,      // serial data in
  input  wire logic                  cs_n_in,      // chip select, low
  output logic                       sck_rise_out, // one-cycle rise pulse
  output logic                       sck_fall_out, // one-cycle fall pulse
  output logic                       start_out,    // select asserted
  output logic                       end_out,      // select released
  output logic [scf_pkg::CNT_W-1:0]  count_out,    // rises in this frame
  output logic [FRAME_BITS-1:0]      word_out      // shifted-in bits
);

  // elaboration check: the saturating counter must reach past one frame
  if (FRAME_BITS < 4 || FRAME_BITS >= 63) begin : g_bad_frame_bits
    $error("scf_frame_rx: FRAME_BITS out of range");
  end

  logic                      sck_q;
  logic                      cs_n_q;
  logic [scf_pkg::CNT_W-1:0] cnt_q;
  logic [FRAME_BITS-1:0]     sh_q;

  // previous pin levels for edge detection
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      sck_q  <= 1'b0;
      cs_n_q <= 1'b1;
    end else begin
      sck_q  <= sck_in;
      cs_n_q <= cs_n_in;
    end
  end

  assign start_out    = cs_n_q & ~cs_n_in;
  assign end_out      = ~cs_n_q & cs_n_in;
  // edges only count while selected
  assign sck_rise_out = ~cs_n_in & ~sck_q & sck_in;
  assign sck_fall_out = ~cs_n_in & sck_q & ~sck_in;

  // rise counter saturates so long frames never wrap back to sixteen
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      cnt_q <= '0;
    end else if (start_out) begin
      cnt_q <= '0;
    end else if (sck_rise_out && cnt_q != scf_pkg::CNT_MAX) begin
      cnt_q <= cnt_q + 6'h01;
    end
  end

  // msb first; oldest bit ends at the top after a full frame
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      sh_q <= '0;
    end else if (sck_rise_out) begin
      sh_q <= {sh_q[FRAME_BITS-2:0], mosi_in};
    end
  end

  assign count_out = cnt_q;
  assign word_out  = sh_q;

endmodule
`default_nettype wire

/* logic/scf_sysconfig.sv */
/*
  System configuration register reached through the serial frame port.
  Holds the stored configuration, returns the selected feedback word and
  flags frames whose clock count is not sixteen.
  Assumes a host master that holds select low for a whole frame, changes
  data on the falling clock edge and samples it on the rising edge, and
  pins that are already synchronous to clk_in.
*/
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// - frames whose top two bits are 10 address this configuration register.
// - readback select one returns general purpose feedback register 0.
// - readback select zero returns the configuration feedback, settings in force.
// - no-write flag one returns the selected word, configuration unchanged.
// - no-write flag zero returns the selected word and stores the frame.
// - frames not exactly sixteen clocks are ignored and flagged.
// - reset length select bit 8 set chooses the long lengthening time.
// - aux supply code 01 is continuously on, 00 is off.
module scf_sysconfig #(
  parameter int unsigned FRAME_BITS = scf_pkg::FRAME_BITS
) (
  input  wire logic                    clk_in,          // system clock
  input  wire logic                    nrst_in,         // async reset, low
  input  wire logic                    sck_in,          // serial clock
  input  wire logic                    mosi_in,         // serial data in
  input  wire logic                    cs_n_in,         // chip select, low
  input  wire logic [FRAME_BITS-1:0]   gp_feedback0_in, // general feedback 0
  output logic                         miso_out,        // serial data out
  output logic                         miso_oe_out,     // data out enable
  output logic                         count_fail_out,  // bad clock count
  output logic                         reset_length_select_out, // long time
  output logic [1:0]                   aux_supply_control_out,  // aux code
  output logic                         aux_supply_on_out,       // aux on
  output logic [scf_pkg::CFG_W-1:0]    config_out       // stored settings
);

  // elaboration check: the field map below is only laid out for sixteen bits
  if (FRAME_BITS != scf_pkg::FRAME_BITS) begin : g_bad_frame_bits
    $error("scf_sysconfig: frame layout is fixed at sixteen bits");
  end

  logic                      rise;
  logic                      fall;
  logic                      start;
  logic                      fin;
  logic [scf_pkg::CNT_W-1:0] cnt;
  logic [FRAME_BITS-1:0]     word;

  scf_frame_rx #(
    .FRAME_BITS (FRAME_BITS)
  ) u_rx (
    .clk_in       (clk_in),
    .nrst_in      (nrst_in),
    .sck_in       (sck_in),
    .mosi_in      (mosi_in),
    .cs_n_in      (cs_n_in),
    .sck_rise_out (rise),
    .sck_fall_out (fall),
    .start_out    (start),
    .end_out      (fin),
    .count_out    (cnt),
    .word_out     (word)
  );

  scf_pkg::scf_state_t state_q;
  scf_pkg::scf_state_t state_d;

  logic                      hit_q;      // address matched this register
  logic                      rrs_q;      // readback select of this frame
  logic                      nowr_q;     // no-write flag of this frame
  logic [scf_pkg::CFG_W-1:0] cfg_q;
  logic [FRAME_BITS-1:0]     reply;
  logic                      miso_q;
  logic                      oe_q;
  logic                      fail_q;
  logic                      good_len;
  logic                      in_frame;   // select fell, not yet released
  logic                      commit;     // store this frame's settings
  logic                      aon_q;      // aux supply plainly on
  logic [3:0]                tx_idx;

  // index of the first reply bit; the shift below walks down from here
  localparam logic [3:0] LAST_IDX = 4'(FRAME_BITS - 1);

  // frame sequencing
  always_comb begin
    state_d = state_q;
    case (state_q)
      scf_pkg::SCF_IDLE: begin
        if (start) begin
          state_d = scf_pkg::SCF_ACTIVE;
        end
      end
      scf_pkg::SCF_ACTIVE: begin
        if (fin) begin
          state_d = scf_pkg::SCF_CLOSE;
        end
      end
      scf_pkg::SCF_CLOSE: begin
        // a new select may already fall in the closing cycle
        if (start) begin
          state_d = scf_pkg::SCF_ACTIVE;
        end else begin
          state_d = scf_pkg::SCF_IDLE;
        end
      end
      default: begin
        state_d = scf_pkg::SCF_IDLE;
      end
    endcase
  end

  // state register; the state only gates the commit, decode runs off the counter
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      state_q <= scf_pkg::SCF_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  // header decode as the bits arrive
  // bit 12 goes out right after bit 13 lands, so the select cannot wait for frame end
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      hit_q  <= 1'b0;
      rrs_q  <= 1'b0;
      nowr_q <= 1'b1;
    end else if (start) begin
      hit_q  <= 1'b0;
      rrs_q  <= 1'b0;
      nowr_q <= 1'b1;
    end else if (rise && cnt == scf_pkg::CNT_ADDR_DONE - 6'h01) begin
      hit_q <= ({word[0], mosi_in} == scf_pkg::ADDR_SYSCFG);
    end else if (rise && cnt == scf_pkg::CNT_RRS_DONE - 6'h01) begin
      rrs_q <= mosi_in;
    end else if (rise && cnt == scf_pkg::CNT_RRS_DONE) begin
      nowr_q <= mosi_in;
    end
  end

  assign good_len = (cnt == scf_pkg::CNT_FRAME);
  // a release with no matching select fall never writes; select low through reset still counts as a fall
  assign in_frame = (state_q == scf_pkg::SCF_ACTIVE);
  // nothing is stored before select rises, so a cut frame leaves the settings whole
  assign commit   = fin && in_frame && good_len && hit_q && !nowr_q;

  // commit only on a full sixteen-clock frame to this register
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      cfg_q <= scf_pkg::CFG_RESET;
    end else if (commit) begin
      cfg_q <= word[scf_pkg::CFG_W-1:0];
    end
  end

  // plain-on decode held in its own flop so the pin comes straight from a register
  // reset settings hold code 00, which is off
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      aon_q <= 1'b0;
    end else if (commit) begin
      aon_q <= (word[scf_pkg::AUX_HI:scf_pkg::AUX_LO] == scf_pkg::AUX_ON);
    end
  end

  // count failure pulse for any frame, whatever its address
  // a pulse only; any sticky flag and its interrupt sit outside this block
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      fail_q <= 1'b0;
    end else begin
      fail_q <= fin && !good_len;
    end
  end

  // reply word: address echo, zero, then the selected feedback
  // bit 13 leaves before readback select is sampled, so it is always zero
  always_comb begin
    reply = '0;
    reply[scf_pkg::ADDR_HI:scf_pkg::ADDR_LO] = scf_pkg::ADDR_SYSCFG;
    if (rrs_q) begin
      reply[scf_pkg::NOWR_POS:0] = gp_feedback0_in[scf_pkg::NOWR_POS:0];
    end else begin
      reply[scf_pkg::CFG_W-1:0] = cfg_q;
    end
  end

  // next bit to present is indexed by rises seen so far
  assign tx_idx = LAST_IDX - cnt[3:0];

  // data out changes on falling edges; the first bit is ready at select
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      miso_q <= 1'b0;
    end else if (start) begin
      miso_q <= reply[scf_pkg::ADDR_HI];
    end else if (fall && cnt < scf_pkg::CNT_FRAME) begin
      miso_q <= reply[tx_idx];
    end
  end

  // drive the data line only while selected so other slaves may share it
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      oe_q <= 1'b0;
    end else begin
      oe_q <= ~cs_n_in;
    end
  end

  // output pins, all straight from registers
  assign miso_out                = miso_q;
  assign miso_oe_out             = oe_q;
  assign count_fail_out          = fail_q;
  assign config_out              = cfg_q;
  assign reset_length_select_out = cfg_q[scf_pkg::RLC_POS];
  assign aux_supply_control_out  = cfg_q[scf_pkg::AUX_HI:scf_pkg::AUX_LO];
  // cyclic codes leave the plain on level low; the cycler reads the code
  assign aux_supply_on_out       = aon_q;

endmodule
`default_nettype wire

/* tb/scf_sysconfig_asserts.sv */
/* checker for the configuration frame block.
   assumes it is bound to scf_sysconfig and sees only its ports. */
`timescale 1ns/1ps
`default_nettype none
module scf_sysconfig_asserts (
  input wire logic                      clk_in,                  // system clock
  input wire logic                      nrst_in,                 // async reset, low
  input wire logic                      sck_in,                  // serial clock
  input wire logic                      cs_n_in,                 // select, low
  input wire logic                      miso_out,                // reply bit
  input wire logic                      miso_oe_out,             // reply enable
  input wire logic                      count_fail_out,          // bad count pulse
  input wire logic                      reset_length_select_out, // long time
  input wire logic [1:0]                aux_supply_control_out,  // aux code
  input wire logic                      aux_supply_on_out,       // aux on
  input wire logic [scf_pkg::CFG_W-1:0] config_out               // stored settings
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (!nrst_in);

  // reply opens with the first address bit, a driven one
  first_bit_a: assert property ($fell(cs_n_in) |=> miso_out && miso_oe_out)
    else $error("first reply bit not one");
  // reply moves only one clock after a seen serial fall
  miso_step_a: assert property ($changed(miso_out) && !cs_n_in && !$past(cs_n_in, 2) |->
    $past(sck_in, 2) && !$past(sck_in)) else $error("reply bit moved off a fall");
  // stored settings change only right after select release
  cfg_hold_a: assert property (!$rose(cs_n_in) |=> $stable(config_out))
    else $error("settings changed outside frame end");
  fail_pulse_a: assert property (count_fail_out |-> $past(cs_n_in) && !$past(cs_n_in, 2))
    else $error("count failure not at frame end");
  fail_short_a: assert property (count_fail_out |=> !count_fail_out)
    else $error("count failure longer than one clock");
  fail_nowrite_a: assert property (count_fail_out |-> $stable(config_out))
    else $error("bad frame wrote settings");
  rlc_map_a: assert property (reset_length_select_out == config_out[8])
    else $error("reset length output not stored bit");
  aux_on_a: assert property (aux_supply_on_out == (aux_supply_control_out == 2'h1) &&
    aux_supply_control_out == config_out[7:6]) else $error("aux supply decode wrong");

  cover property (count_fail_out);
  cover property ($changed(config_out));
  cover property (aux_supply_on_out);
endmodule
bind scf_sysconfig scf_sysconfig_asserts scf_sysconfig_asserts_inst (.clk_in, .nrst_in, .sck_in,
  .cs_n_in, .miso_out, .miso_oe_out, .count_fail_out, .reset_length_select_out,
  .aux_supply_control_out, .aux_supply_on_out, .config_out);
`default_nettype wire

/* tb/scf_host_model.sv */
/* host master model: sends one frame of any clock count, msb first.
   assumes tasks are entered at a falling clk edge. */
`timescale 1ns/1ps
`default_nettype none
module scf_host_model (
  input  wire logic clk_in,   // system clock
  input  wire logic miso_in,  // reply bit
  output logic      sck_out,  // serial clock, idles low
  output logic      mosi_out, // serial data
  output logic      cs_n_out  // select, low
);
  initial begin
    sck_out = 1'b0;
    mosi_out = 1'b1;
    cs_n_out = 1'b1;
  end
  // sck is only two clocks high and low, half the clk_in/2 rate the receiver allows
  task automatic xfer(input logic [15:0] w, input int n, output logic [15:0] r);
    cs_n_out = 1'b0;
    for (int i = 0; i < n; i++) begin
      mosi_out = (i < 16) ? w[15 - i] : 1'b0;
      repeat (2) @(negedge clk_in);
      r = {r[14:0], miso_in};
      sck_out = 1'b1;
      repeat (2) @(negedge clk_in);
      sck_out = 1'b0;
    end
    repeat (2) @(negedge clk_in);
    cs_n_out = 1'b1;
    // released data line must not keep looking valid
    mosi_out = ~mosi_out;
    repeat (3) @(negedge clk_in);
  endtask
endmodule
`default_nettype wire

/* tb/tb.sv */
/* testbench for scf_sysconfig: frames from the host model, checked replies.
   assumes the checker is bound in and the design runs at 50 MHz. */
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin failures++; \
  $display("MISMATCH t=%0t got %h exp %h", $time, a, b); end end
module tb;
  logic              clk_in = 1'b0;
  logic              nrst_in = 1'b0;
  logic [15:0]       gp_fb = 16'h0000;
  logic [15:0]       r;
  logic [3:0]        nfail = 4'h0;
  int                failures = 0;
  int                comparisons = 0;
  wire logic         sck, mosi, cs_n, miso, oe, fail, reset_length_select, aon;
  wire logic         miso_line;
  wire logic [1:0]   aux;
  wire logic [8:0]   cfg;

  always #10 clk_in = ~clk_in;
  // count failure pulses, each should be seen once; sampled mid-cycle, off the launch edge
  always @(negedge clk_in) if (fail === 1'b1) nfail <= nfail + 4'h1;

  // no pull on the reply line: released, it shows the inverse so a late enable is caught
  assign miso_line = oe ? miso : ~miso;

  scf_host_model scf_host_model_inst (.clk_in(clk_in), .miso_in(miso_line), .sck_out(sck),
    .mosi_out(mosi), .cs_n_out(cs_n));
  scf_sysconfig scf_sysconfig_inst (.clk_in(clk_in), .nrst_in(nrst_in), .sck_in(sck),
    .mosi_in(mosi), .cs_n_in(cs_n), .gp_feedback0_in(gp_fb), .miso_out(miso),
    .miso_oe_out(oe), .count_fail_out(fail), .reset_length_select_out(reset_length_select),
    .aux_supply_control_out(aux), .aux_supply_on_out(aon), .config_out(cfg));

  task automatic final_report;
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  task automatic tend(input string s);
    $display("test %s done", s);
  endtask

  // watchdog, far above the run length
  initial begin
    repeat (20000) @(posedge clk_in);
    failures++;
    final_report();
  end

  initial begin
    repeat (12) @(negedge clk_in);
    nrst_in = 1'b1;
    repeat (2) @(negedge clk_in);
    `CHK({cfg, fail, oe}, 11'h000)
    tend("reset");
    scf_host_model_inst.xfer(16'h8145, 16, r);
    `CHK(r, 16'h8000)
    `CHK({reset_length_select, aux, aon}, 4'hB)
    scf_host_model_inst.xfer(16'h9000, 16, r);
    `CHK(r, 16'h8145)
    gp_fb = 16'h5A5A;
    scf_host_model_inst.xfer(16'hB000, 16, r);
    `CHK(r, 16'h9A5A)
    `CHK(cfg, 9'h145)
    tend("readback");
    // every aux code, readback of feedback 0 while writing
    for (int c = 0; c < 4; c++) begin
      scf_host_model_inst.xfer(16'hA000 | 16'(c << 6), 16, r);
      `CHK(r, 16'h9A5A)
      `CHK({aux, aon}, {2'(c), c == 1})
    end
    `CHK(reset_length_select, 1'b0)
    tend("aux");
    // one clock short and one too many
    for (int n = 15; n <= 17; n += 2) begin
      scf_host_model_inst.xfer(16'h81FF, n, r);
      `CHK(cfg, 9'h0C0)
    end
    `CHK(nfail, 4'h2)
    tend("count");
    // the other three addresses leave the settings alone
    for (int a = 0; a < 4; a++) begin
      if (a != 2) begin
        scf_host_model_inst.xfer({2'(a), 14'h01FF}, 16, r);
        `CHK(cfg, 9'h0C0)
      end
    end
    `CHK(nfail, 4'h2)
    tend("address");
    final_report();
  end
endmodule
`default_nettype wire
